// ### hw/adc_ctrl_defines.svh
// Offsets, field positions, reset values and timing counts of the converter control
// Assumes inclusion by bare name from every file that needs them
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// Command byte decode
`define CMD_CONV_BIT      7
`define CMD_SETUP_BIT     6
`define GPIO_CMD_CODE     8'h03

// Conversion command fields
`define CONV_CHSEL_HI     5
`define CONV_CHSEL_LO     3
`define CONV_SCAN_HI      2
`define CONV_SCAN_LO      1
`define CONV_TEMP_BIT     0

// Setup command fields
`define SETUP_CLK_HI      5
`define SETUP_CLK_LO      4
`define SETUP_REF_HI      3
`define SETUP_REF_LO      2
`define SETUP_DIFF_HI     1
`define SETUP_DIFF_LO     0

// Reset values, strap wake-up codes and external clock mode
`define CLK_MODE_RESET    2'h2
`define REF_MODE_RESET    2'h0
`define CLK_MODE_EXT      2'h3
`define DAC_CODE_LOW      10'h000
`define DAC_CODE_HIGH     10'h3ff

// Pin sharing
`define START_CHANNEL     3'h7
`define SECREF_CHANNEL    3'h6
`define SHARED_PAIR       2'h3

// Timing and arithmetic
`define REF_SETTLE_CYCLES 8'd188
`define STRAP_SETTLE      2'h2
`define REPEAT_STEP       5'h04
`define TEMP_K_OFFSET     12'h889

`endif

// ### hw/adc_ctrl_pkg.sv
// Types shared by the serial receiver and the converter control
// Assumes the defines header is available to the files that use the fields
package adc_ctrl_pkg;

	typedef enum logic [1:0] {
		CMD_NONE  = 2'b00,
		CMD_CONV  = 2'b01,
		CMD_SETUP = 2'b10,
		CMD_GPIO  = 2'b11
	} cmd_e;

	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,
		S_REF_WAIT = 3'b001,
		S_TEMP_HI  = 3'b010,
		S_TEMP_LO  = 3'b011,
		S_PICK     = 3'b100,
		S_CONV     = 3'b101,
		S_DONE     = 3'b110,
		S_NEXT     = 3'b111
	} seq_e;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic       frame_start;
		logic [7:0] data;
	} rx_byte_s;

	typedef struct packed {
		logic       start;
		logic [2:0] channel;
		logic       diff;
		logic       bipolar;
		logic       temp;
		logic       bias_high;
	} adc_req_s;

	typedef struct packed {
		logic adc_ext;
		logic dac_ext;
		logic adc_diff_ref;
		logic sec_ref_is_input;
	} ref_cfg_s;

	typedef struct packed {
		logic [9:0] code;
		logic       pull_ref;
		logic       pull_gnd;
		logic       buf_pd;
	} dac_wake_s;

	typedef struct packed {
		logic       cs_m;
		logic       cs_s;
		logic       cs_d;
		logic       sck_m;
		logic       sck_s;
		logic       sck_d;
		logic       din_m;
		logic       din_s;
		logic [2:0] bits;
		logic [7:0] shift;
		logic       first;
		rx_byte_s   out;
	} rx_state_s;

	typedef struct packed {
		logic        cnv_m;
		logic        cnv_s;
		logic        cnv_d;
		logic        strap_m;
		logic        strap_s;
		logic [1:0]  strap_cnt;
		logic        strap_done;
		dac_wake_s   dac;
		logic [1:0]  clk_mode;
		logic [1:0]  ref_mode;
		logic [1:0]  diff_sel;
		logic [3:0]  pair_uni;
		logic [3:0]  pair_bip;
		logic [2:0]  chan;
		logic [1:0]  scan;
		logic        temp_req;
		cmd_e        cmd;
		logic        gpio_taken;
		logic [3:0]  gp;
		seq_e        seq;
		logic        busy;
		logic [2:0]  cur_ch;
		logic [4:0]  reps;
		logic [7:0]  wait_cnt;
		logic [11:0] temp_hi;
		adc_req_s    adc;
		logic        result_valid;
		logic        result_temp;
		logic [11:0] result_data;
		logic [11:0] temp_result;
		logic        eoc_n;
		ref_cfg_s    refc;
		logic        ref_on;
		logic        int_osc_en;
		logic        ext_timing;
	} ctrl_state_s;

endpackage

// ### hw/spi_byte_rx.sv
// Serial byte receiver for the four-wire command port
// Assumes raw pins from the host; sclk is far slower than ref_clk
`timescale 1ns/1ps
module spi_byte_rx
	import adc_ctrl_pkg::*;
(
	// Clock and control
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	// Serial pins
	input  wire logic                  cs_n,
	input  wire logic                  sclk,
	input  wire logic                  din,
	// Received bytes
	output adc_ctrl_pkg::rx_byte_s     rx
);
	import adc_ctrl_pkg::*;

	rx_state_s st;
	rx_state_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.out.valid = 1'b0;
		next_st.out.frame_start = 1'b0;
		next_st.cs_m = cs_n;
		next_st.cs_s = st.cs_m;
		next_st.cs_d = st.cs_s;
		next_st.sck_m = sclk;
		next_st.sck_s = st.sck_m;
		next_st.sck_d = st.sck_s;
		next_st.din_m = din;
		next_st.din_s = st.din_m;
		// Command byte is the first one after select
		if (st.cs_d && !st.cs_s)
		begin
			next_st.bits = 3'h0;
			next_st.first = 1'b1;
			next_st.out.frame_start = 1'b1;
		end
		// Data is taken on the falling serial clock edge
		else if (!st.cs_s && st.sck_d && !st.sck_s)
		begin
			next_st.shift = {st.shift[6:0], st.din_s};
			next_st.bits = st.bits + 3'h1;
			if (st.bits == 3'h7)
			begin
				next_st.out.valid = 1'b1;
				next_st.out.first = st.first;
				next_st.out.data = {st.shift[6:0], st.din_s};
				next_st.first = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			st <= '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, default: '0};
		else if (ce)
			st <= next_st;
	end

	assign rx = st.out;
endmodule

// ### hw/adc_scan_and_setup_control.sv
// Command decode, clock and reference setup, scan sequencing and wake-up control
// Assumes an analog core answering conversion requests on ref_clk and a host on the serial pins
//
// Function
// - Strap low: DAC code 000h, pulled down
// - Strap high: DAC code 3FFh, pulled up
// - Internal oscillator runs in clock modes 00-10
// - Mode 11: serial clock times conversions
// - Reference field picks ADC and DAC reference
// - Secondary pin is input for 00/10
// - Conversion byte bit 0 requests temperature
// - Temperature is high minus low minus offset
// - Temperature twos complement, internal reference only
// - Temperature conversion runs first, read first
// - New temperature overwrites unread old one
// - Modes 10/11 start on write, else pin
// - Skip channels used as start or reference
// - Differential pairs ignore channel select LSB
// - Scan 00/01 one result per channel/pair
// - Scan 10 repeats by repeat count bits
// - Scan 11 converts selected channel once
// - Setup byte holds clock, reference, diff fields
// - Reference stays on under three conditions
// - Wait 188 cycles before temperature when on
// - MSB set decodes conversion write
// - Bits 7:6 = 01 decode setup write
// - Scan 00 from 0, 01 to top
// - End-of-conversion low at finish outside mode 11, set high by select or start
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_scan_and_setup_control
(
	// Clock and control
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	// Serial and start pins
	input  wire logic                  cs_n,
	input  wire logic                  sclk,
	input  wire logic                  din,
	input  wire logic                  conversion_start_pin,
	input  wire logic                  output_reset_select_strap,
	// Power and averaging state from other blocks
	input  wire logic                  force_bandgap_on,
	input  wire logic                  dac_any_powered,
	input  wire logic                  dac_any_pd_to_ref,
	input  wire logic [1:0]            repeat_count,
	// Analog core answer
	input  wire logic                  adc_done,
	input  wire logic [11:0]           adc_data,
	// Analog core request and setup
	output adc_ctrl_pkg::adc_req_s     adc_req,
	output adc_ctrl_pkg::ref_cfg_s     ref_cfg,
	output adc_ctrl_pkg::dac_wake_s    dac_wake,
	output logic                       ref_on,
	output logic                       int_osc_en,
	output logic                       ext_timing,
	// Results to the result buffer
	output logic                       result_valid,
	output logic                       result_temp,
	output logic [11:0]                result_data,
	// Status and general-purpose pins
	output logic                       eoc_n,
	output logic                       gp_pin_high_drive_0,
	output logic                       gp_pin_high_drive_1,
	output logic                       gp_pin_low_drive_0,
	output logic                       gp_pin_low_drive_1
);
	import adc_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	rx_byte_s    rx;
	ctrl_state_s st;
	ctrl_state_s next_st;

	spi_byte_rx u_rx
	(
		.ref_clk (ref_clk),
		.reset   (reset),
		.ce      (ce),
		.cs_n    (cs_n),
		.sclk    (sclk),
		.din     (din),
		.rx      (rx)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic pair_is_diff(input ctrl_state_s s, input logic [2:0] ch);
		pair_is_diff = s.pair_uni[ch[2:1]] | s.pair_bip[ch[2:1]];
	endfunction

	function automatic logic [2:0] eff_ch(input ctrl_state_s s, input logic [2:0] ch);
		eff_ch = pair_is_diff(s, ch) ? {ch[2:1], 1'b0} : ch;
	endfunction

	function automatic logic blocked(input ctrl_state_s s, input logic [2:0] ch);
		logic pin_used;
		logic ref_used;
		pin_used = !s.clk_mode[1];
		ref_used = s.ref_mode[0];
		if (pair_is_diff(s, ch))
			blocked = (ch[2:1] == `SHARED_PAIR) && (pin_used || ref_used);
		else
			blocked = (pin_used && ch == `START_CHANNEL) || (ref_used && ch == `SECREF_CHANNEL);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic       cnv_fall;
	logic       start_req;
	logic [1:0] scan_eff;
	logic [3:0] adv_next;
	logic       adv_last;
	logic [2:0] cur_eff;

	always_comb
	begin
		next_st = st;
		start_req = 1'b0;
		next_st.adc.start = 1'b0;
		next_st.result_valid = 1'b0;
		next_st.cnv_m = conversion_start_pin;
		next_st.cnv_s = st.cnv_m;
		next_st.cnv_d = st.cnv_s;
		cnv_fall = st.cnv_d && !st.cnv_s;
		next_st.strap_m = output_reset_select_strap;
		next_st.strap_s = st.strap_m;
		// Strap is taken once, after the synchroniser has filled
		if (!st.strap_done)
		begin
			if (st.strap_cnt == `STRAP_SETTLE)
			begin
				next_st.strap_done = 1'b1;
				if (st.strap_s)
					next_st.dac = '{code: `DAC_CODE_HIGH, pull_ref: 1'b1, pull_gnd: 1'b0, buf_pd: 1'b1};
				else
					next_st.dac = '{code: `DAC_CODE_LOW, pull_ref: 1'b0, pull_gnd: 1'b1, buf_pd: 1'b1};
			end
			else
				next_st.strap_cnt = st.strap_cnt + 2'h1;
		end
		if (rx.valid && rx.first)
		begin
			if (rx.data[`CMD_CONV_BIT])
			begin
				next_st.cmd = CMD_CONV;
				// Writes during a running scan are dropped so the scan stays coherent
				if (st.seq == S_IDLE)
				begin
					next_st.chan = rx.data[`CONV_CHSEL_HI:`CONV_CHSEL_LO];
					next_st.scan = rx.data[`CONV_SCAN_HI:`CONV_SCAN_LO];
					next_st.temp_req = rx.data[`CONV_TEMP_BIT];
					start_req = st.clk_mode[1];
				end
			end
			else if (rx.data[`CMD_SETUP_BIT])
			begin
				next_st.cmd = CMD_SETUP;
				next_st.clk_mode = rx.data[`SETUP_CLK_HI:`SETUP_CLK_LO];
				next_st.ref_mode = rx.data[`SETUP_REF_HI:`SETUP_REF_LO];
				next_st.diff_sel = rx.data[`SETUP_DIFF_HI:`SETUP_DIFF_LO];
			end
			else if (rx.data == `GPIO_CMD_CODE)
			begin
				next_st.cmd = CMD_GPIO;
				next_st.gpio_taken = 1'b0;
			end
			else
				next_st.cmd = CMD_NONE;
		end
		else if (rx.valid)
		begin
			if (st.cmd == CMD_SETUP && st.diff_sel == 2'h2)
				next_st.pair_uni = rx.data[3:0];
			if (st.cmd == CMD_SETUP && st.diff_sel == 2'h3)
				next_st.pair_bip = rx.data[3:0];
			if (st.cmd == CMD_GPIO && !st.gpio_taken)
			begin
				next_st.gp = rx.data[3:0];
				next_st.gpio_taken = 1'b1;
			end
		end
		if (cnv_fall && !st.clk_mode[1] && st.seq == S_IDLE)
			start_req = 1'b1;
		// Select or start clears end flag
		if (rx.frame_start || cnv_fall)
			next_st.eoc_n = 1'b1;

		// Scanning is not available with the external conversion clock
		scan_eff = (st.clk_mode == `CLK_MODE_EXT) ? 2'h3 : st.scan;
		cur_eff = eff_ch(st, st.cur_ch);
		adv_next = {1'b0, cur_eff} + (pair_is_diff(st, st.cur_ch) ? 4'h2 : 4'h1);
		// Last step: past the range for scan 00/01, repeat count spent for 10, at once for 11
		unique case (scan_eff)
			2'h0: adv_last = adv_next > {1'b0, eff_ch(st, st.chan)};
			2'h1: adv_last = adv_next[3];
			2'h2: adv_last = st.reps == 5'h01;
			2'h3: adv_last = 1'b1;
		endcase

		unique case (st.seq)
			S_IDLE:
			begin
				if (start_req)
				begin
					next_st.cur_ch = (next_st.scan == 2'h0) ? 3'h0 : next_st.chan;
					next_st.reps = {1'b0, repeat_count, 2'h0} + `REPEAT_STEP;
					if (next_st.temp_req && st.ref_on)
					begin
						next_st.seq = S_REF_WAIT;
						next_st.wait_cnt = `REF_SETTLE_CYCLES - 8'd1;
					end
					else if (next_st.temp_req)
						next_st.seq = S_TEMP_HI;
					else
						next_st.seq = S_PICK;
				end
			end
			S_REF_WAIT:
			begin
				if (st.wait_cnt == 8'd0)
					next_st.seq = S_TEMP_HI;
				else
					next_st.wait_cnt = st.wait_cnt - 8'd1;
			end
			S_TEMP_HI, S_TEMP_LO:
			begin
				// Core uses internal reference whenever temp is set
				if (!st.busy)
				begin
					next_st.busy = 1'b1;
					next_st.adc = '{start: 1'b1, channel: 3'h0, diff: 1'b0, bipolar: 1'b0,
						temp: 1'b1, bias_high: (st.seq == S_TEMP_HI)};
				end
				else if (adc_done && st.seq == S_TEMP_HI)
				begin
					next_st.busy = 1'b0;
					next_st.temp_hi = adc_data;
					next_st.seq = S_TEMP_LO;
				end
				else if (adc_done)
				begin
					next_st.busy = 1'b0;
					next_st.temp_result = st.temp_hi - adc_data - `TEMP_K_OFFSET;
					next_st.result_data = st.temp_hi - adc_data - `TEMP_K_OFFSET;
					next_st.result_temp = 1'b1;
					next_st.result_valid = 1'b1;
					next_st.seq = S_PICK;
				end
			end
			S_PICK:
			begin
				if (blocked(st, st.cur_ch))
					next_st.seq = S_NEXT;
				else
				begin
					next_st.adc = '{start: 1'b1, channel: cur_eff,
						diff: pair_is_diff(st, st.cur_ch), bipolar: st.pair_bip[st.cur_ch[2:1]],
						temp: 1'b0, bias_high: 1'b0};
					next_st.seq = S_CONV;
				end
			end
			S_CONV:
			begin
				if (adc_done)
				begin
					next_st.result_data = adc_data;
					next_st.result_temp = 1'b0;
					next_st.result_valid = 1'b1;
					next_st.seq = S_NEXT;
				end
			end
			S_NEXT:
			begin
				if (adv_last)
					next_st.seq = S_DONE;
				else
				begin
					next_st.cur_ch = (scan_eff == 2'h2) ? st.cur_ch : adv_next[2:0];
					next_st.reps = st.reps - 5'h01;
					next_st.seq = S_PICK;
				end
			end
			S_DONE:
			begin
				next_st.eoc_n = 1'b0;
				next_st.seq = S_IDLE;
			end
		endcase
		if (next_st.clk_mode == `CLK_MODE_EXT)
			next_st.eoc_n = 1'b1;

		next_st.refc.adc_ext = next_st.ref_mode[0];
		next_st.refc.dac_ext = next_st.ref_mode != 2'h0;
		next_st.refc.adc_diff_ref = next_st.ref_mode == 2'h3;
		next_st.refc.sec_ref_is_input = !next_st.ref_mode[0];
		next_st.ref_on = force_bandgap_on ||
			(next_st.ref_mode == 2'h0 && (dac_any_powered || dac_any_pd_to_ref));
		next_st.int_osc_en = next_st.clk_mode != `CLK_MODE_EXT;
		next_st.ext_timing = next_st.clk_mode == `CLK_MODE_EXT;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			st <= '{cnv_m: 1'b1, cnv_s: 1'b1, cnv_d: 1'b1, clk_mode: `CLK_MODE_RESET,
				ref_mode: `REF_MODE_RESET, cmd: CMD_NONE, seq: S_IDLE, eoc_n: 1'b1,
				dac: '{code: `DAC_CODE_LOW, pull_ref: 1'b0, pull_gnd: 1'b0, buf_pd: 1'b1},
				refc: '{sec_ref_is_input: 1'b1, default: 1'b0}, int_osc_en: 1'b1, default: '0};
		else if (ce)
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign adc_req = st.adc;
	assign ref_cfg = st.refc;
	assign dac_wake = st.dac;
	assign ref_on = st.ref_on;
	assign int_osc_en = st.int_osc_en;
	assign ext_timing = st.ext_timing;
	assign result_valid = st.result_valid;
	assign result_temp = st.result_temp;
	assign result_data = st.result_data;
	assign eoc_n = st.eoc_n;
	assign gp_pin_high_drive_0 = st.gp[0];
	assign gp_pin_high_drive_1 = st.gp[1];
	assign gp_pin_low_drive_0 = st.gp[2];
	assign gp_pin_low_drive_1 = st.gp[3];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset || !ce);

	a_dac_low_wake: assert property ($rose(st.strap_done) && !$past(st.strap_s) |->
		st.dac.code == `DAC_CODE_LOW && st.dac.pull_gnd && st.dac.buf_pd)
		else $error("low strap wake-up wrong");
	a_dac_high_wake: assert property ($rose(st.strap_done) && $past(st.strap_s) |->
		st.dac.code == `DAC_CODE_HIGH && st.dac.pull_ref && st.dac.buf_pd)
		else $error("high strap wake-up wrong");
	a_osc_by_mode: assert property (int_osc_en == (st.clk_mode != 2'h3))
		else $error("oscillator enable disagrees with clock mode");
	a_ext_clk_eoc: assert property (st.clk_mode == 2'h3 |-> eoc_n && ext_timing)
		else $error("external clock mode shows end of conversion");
	a_ref_decode: assert property (ref_cfg.adc_diff_ref == (st.ref_mode == 2'h3) &&
		ref_cfg.sec_ref_is_input == !st.ref_mode[0])
		else $error("reference decode wrong");
	a_write_start: assert property (rx.valid && rx.first && rx.data[7] &&
		st.clk_mode[1] && st.seq == S_IDLE |=> st.seq != S_IDLE)
		else $error("conversion write did not start scan");
	a_temp_first: assert property (st.seq == S_IDLE ##1 st.seq != S_IDLE && st.temp_req
		|-> st.seq == S_REF_WAIT || st.seq == S_TEMP_HI)
		else $error("temperature not first");
	a_ref_wait_len: assert property ($rose(st.seq == S_REF_WAIT) |->
		st.wait_cnt == 8'd187)
		else $error("reference wait length wrong");
	a_temp_store: assert property (result_valid && result_temp |->
		result_data == st.temp_result)
		else $error("temperature result not stored");
	a_skip_shared: assert property (adc_req.start && !adc_req.temp |->
		!blocked(st, adc_req.channel) && !(adc_req.diff && adc_req.channel[0]))
		else $error("blocked or odd differential channel converted");
	a_done_eoc: assert property (st.seq == S_DONE && next_st.clk_mode != 2'h3 |=> !eoc_n)
		else $error("end of conversion not flagged");

	c_temp_scan: cover property (result_valid && result_temp ##[1:200] st.seq == S_DONE);
	c_ref_wait: cover property (st.seq == S_REF_WAIT ##1 st.seq == S_REF_WAIT);
	c_pin_start: cover property (cnv_fall && st.seq == S_IDLE && !st.clk_mode[1]);
	c_gpio_write: cover property ($rose(st.gpio_taken));
endmodule

// ### verification/host_spi_model.sv
// Host serial controller model sending command frames
// Assumes ref_clk at 40 MHz; link clock period 200 ns, idle low between frames
`timescale 1ns/1ps
module host_spi_model
(
	// Clock
	input  wire logic ref_clk,
	// Serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// command byte first
	// Bytes go MSB first, data changes on the rising link edge
	task automatic frame(input logic [23:0] bytes, input int n);
		wait_clk(1);
		cs_n <= 1'b0;
		wait_clk(4);
		for (int i = 23; i >= 24 - 8 * n; i--)
		begin
			wait_clk(1);
			sclk <= 1'b1;
			din  <= bytes[i];
			wait_clk(4);
			sclk <= 1'b0;
			wait_clk(3);
		end
		wait_clk(4);
		cs_n <= 1'b1;
		// Released line: no pull, so show the inverse of the last bit
		din  <= ~din;
		wait_clk(8);
	endtask
endmodule

// ### verification/adc_scan_and_setup_control_tb.sv
// Self-checking bench for the converter control block
// Assumes the host model drives the serial pins and an inline core answers requests
`timescale 1ns/1ps
module adc_scan_and_setup_control_tb;
	import adc_ctrl_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        conversion_start_pin = 1'b1;
	logic        output_reset_select_strap = 1'b1;
	logic        dac_any_powered = 1'b0;
	logic        force_bandgap_on = 1'b0;
	logic        dac_any_pd_to_ref = 1'b0;
	logic [1:0]  repeat_count = 2'h0;
	logic        adc_done = 1'b0;
	logic [11:0] adc_data = 12'h000;
	logic        cs_n;
	logic        sclk;
	logic        din;
	adc_req_s    adc_req;
	ref_cfg_s    ref_cfg;
	dac_wake_s   dac_wake;
	logic        ref_on;
	logic        int_osc_en;
	logic        ext_timing;
	logic        result_valid;
	logic        result_temp;
	logic [11:0] result_data;
	logic        eoc_n;
	wire  [3:0]  gp;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          cnt = 0;
	int          temp_start_cyc = 0;
	int          t_start = 0;
	logic [15:0] res_q[$];
	logic [15:0] exp_q[$];

	host_spi_model u_host_spi_model (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din));

	adc_scan_and_setup_control u_adc_scan_and_setup_control (
		.ref_clk(ref_clk), .reset(reset), .ce(1'b1), .cs_n(cs_n), .sclk(sclk), .din(din),
		.conversion_start_pin(conversion_start_pin),
		.output_reset_select_strap(output_reset_select_strap),
		.force_bandgap_on(force_bandgap_on), .dac_any_powered(dac_any_powered),
		.dac_any_pd_to_ref(dac_any_pd_to_ref), .repeat_count(repeat_count),
		.adc_done(adc_done), .adc_data(adc_data), .adc_req(adc_req), .ref_cfg(ref_cfg),
		.dac_wake(dac_wake), .ref_on(ref_on), .int_osc_en(int_osc_en),
		.ext_timing(ext_timing), .result_valid(result_valid), .result_temp(result_temp),
		.result_data(result_data), .eoc_n(eoc_n), .gp_pin_high_drive_0(gp[0]),
		.gp_pin_high_drive_1(gp[1]), .gp_pin_low_drive_0(gp[2]), .gp_pin_low_drive_1(gp[3]));

	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Analog core stand-in: answers six cycles after each start
	// Temperature bias codes give hi - lo - 889h = 077h
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		adc_done <= 1'b0;
		if (cnt == 1)
		begin
			adc_done <= 1'b1;
			adc_data <= adc_req.temp ? (adc_req.bias_high ? 12'ha00 : 12'h100)
				: {9'h000, adc_req.channel};
		end
		if (cnt > 0)
			cnt = cnt - 1;
		if (adc_req.start === 1'b1)
			cnt = 6;
		if (adc_req.start === 1'b1 && adc_req.temp === 1'b1 && adc_req.bias_high === 1'b1)
			temp_start_cyc = cyc;
		if (result_valid === 1'b1)
			res_q.push_back({3'h0, result_temp, result_data});
		if (cyc == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic strap);
		@(posedge ref_clk);
		reset <= 1'b1;
		output_reset_select_strap <= strap;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (10) @(posedge ref_clk);
	endtask

	// Runs one scan by write or start pin, then compares the results in order
	task automatic scan_check(input logic [7:0] conv, input logic pin, input logic eoc);
		res_q.delete();
		t_start = cyc;
		if (pin)
		begin
			@(posedge ref_clk);
			conversion_start_pin <= 1'b0;
			repeat (4) @(posedge ref_clk);
			conversion_start_pin <= 1'b1;
		end
		else
			u_host_spi_model.frame({conv, 16'h0000}, 1);
		for (int k = 0; k < 3000 && res_q.size() < exp_q.size(); k++)
			@(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		chk(16'(res_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i])
			chk((i < res_q.size()) ? res_q[i] : 16'hffff, exp_q[i]);
		chk({15'h0, eoc_n}, {15'h0, eoc});
	endtask

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic t_reset();
		do_reset(1'b1);
		chk({3'h0, dac_wake}, {3'h0, 10'h3ff, 3'b101});
		do_reset(1'b0);
		chk({3'h0, dac_wake}, {3'h0, 10'h000, 3'b011});
		chk({12'h0, ref_cfg}, 16'h0001);
		chk({13'h0, int_osc_en, ext_timing, eoc_n}, 16'h0005);
		$display("reset test done");
	endtask

	task automatic t_gpio();
		u_host_spi_model.frame(24'h030a00, 2);
		chk({12'h0, gp}, 16'h000a);
		u_host_spi_model.frame(24'h03050f, 3);
		chk({12'h0, gp}, 16'h0005);
		$display("gpio test done");
	endtask

	task automatic t_setup();
		for (int i = 0; i < 4; i++)
		begin
			u_host_spi_model.frame({8'h40 | 8'(i << 4) | 8'(i << 2), 16'h0}, 1);
			chk({12'h0, ref_cfg}, {12'h0, i[0], i != 0, i == 3, ~i[0]});
			chk({14'h0, int_osc_en, ext_timing}, {14'h0, i != 3, i == 3});
		end
		u_host_spi_model.frame(24'h600000, 1);
		$display("setup test done");
	endtask

	// Reference wait is judged as the latency gap between a held-on and an off reference
	task automatic t_temp();
		int lat;
		@(posedge ref_clk);
		force_bandgap_on <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({15'h0, ref_on}, 16'h0001);
		force_bandgap_on <= 1'b0;
		dac_any_pd_to_ref <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({15'h0, ref_on}, 16'h0001);
		dac_any_pd_to_ref <= 1'b0;
		dac_any_powered <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({15'h0, ref_on}, 16'h0001);
		exp_q = '{16'h1077, 16'h0002};
		scan_check(8'h97, 1'b0, 1'b0);
		lat = temp_start_cyc - t_start;
		dac_any_powered <= 1'b0;
		exp_q = '{16'h1077, 16'h0002};
		scan_check(8'h97, 1'b0, 1'b0);
		chk(16'(lat - (temp_start_cyc - t_start)), 16'd188);
		chk({15'h0, ref_on}, 16'h0000);
		$display("temperature test done");
	endtask

	task automatic t_scans();
		u_host_spi_model.frame(24'h640000, 1);
		exp_q = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0007};
		scan_check(8'hb8, 1'b0, 1'b0);
		u_host_spi_model.frame(24'h620400, 2);
		exp_q = '{16'h0004, 16'h0006, 16'h0007};
		scan_check(8'haa, 1'b0, 1'b0);
		exp_q = '{16'h0003, 16'h0003, 16'h0003, 16'h0003};
		scan_check(8'h9c, 1'b0, 1'b0);
		$display("scan test done");
	endtask

	task automatic t_modes();
		u_host_spi_model.frame(24'h400000, 1);
		exp_q.delete();
		scan_check(8'h8e, 1'b0, 1'b1);
		exp_q = '{16'h0001};
		scan_check(8'h00, 1'b1, 1'b0);
		@(posedge ref_clk);
		conversion_start_pin <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk({15'h0, eoc_n}, 16'h0001);
		conversion_start_pin <= 1'b1;
		repeat (40) @(posedge ref_clk);
		u_host_spi_model.frame(24'h700000, 1);
		exp_q = '{16'h0001};
		scan_check(8'h8e, 1'b0, 1'b1);
		$display("clock mode test done");
	endtask

	initial
	begin
		t_reset();
		t_gpio();
		t_setup();
		t_temp();
		t_scans();
		t_modes();
		test_done();
	end
endmodule
